// *** gpio_pkg.sv ***
package gpio_pkg;
	localparam int           NUM_PINS        = 4;
	localparam int           MODE_W          = 2;
	localparam logic [11:0]  OFS_MODE        = 12'h214;
	localparam logic [11:0]  OFS_LEVEL       = 12'h218;
	localparam logic [11:0]  OFS_OUT         = 12'h21c;
	localparam logic [11:0]  OFS_IRQ_STATUS  = 12'h300;
	localparam logic [11:0]  OFS_IRQ_MASK    = 12'h304;
	localparam logic [31:0]  RESET_WORD      = 32'h00000000;
	localparam logic [1:0]   MSI_VEC_W_DUMMY = 2'h0;

	// Pin modes.
	typedef enum logic [1:0] {
		MODE_INPUT = 2'b00,
		MODE_PUSH  = 2'b01,
		MODE_DRAIN = 2'b10,
		MODE_IRQ   = 2'b11
	} pin_mode_type;

	// Register bus request.
	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} bus_req_type;

	// Pin drive bundle.
	typedef struct packed {
		logic [NUM_PINS-1:0] out;
		logic [NUM_PINS-1:0] oe;
	} pin_drive_type;

	// Message interrupt request.
	typedef struct packed {
		logic       valid;
		logic [1:0] vector;
	} msi_req_type;
endpackage

// *** pin_sync.sv ***
`timescale 1ns/10ps
// Two-flop synchroniser with falling edge detection on the second stage.
module pin_sync #(
	parameter int WIDTH = 4
) (
	input  wire logic             clk,   // Core clock.
	input  wire logic             reset, // Synchronous reset.
	input  wire logic [WIDTH-1:0] din,   // Raw pins.
	output logic      [WIDTH-1:0] level, // Synchronised level.
	output logic      [WIDTH-1:0] fall   // One-cycle falling pulse.
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
	} sync_state_type;

	sync_state_type st_r;
	sync_state_type st_nxt;

	// Only the second and third stages feed the edge compare; the first is read by s2 alone.
	always_comb begin
		st_nxt    = st_r;
		st_nxt.s1 = din;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign level = st_r.s2;
	assign fall  = st_r.s3 & ~st_r.s2;
endmodule

// *** gpio_port.sv ***
`timescale 1ns/10ps
// Four-pin general-purpose port with per-pin modes and message interrupts.
module gpio_port
	import gpio_pkg::*;
(
	input  wire logic                          clk,       // Core clock, 100 MHz.
	input  wire logic                          reset,     // Synchronous, active high.
	input  wire gpio_pkg::bus_req_type         bus,       // Register request.
	output logic [31:0]                        rdata,     // Read data, cycle after read.
	input  wire logic [gpio_pkg::NUM_PINS-1:0] pin_in,    // Pin levels.
	output gpio_pkg::pin_drive_type            pin_drv,   // Pin drive and enable.
	output gpio_pkg::msi_req_type              msi,       // Interrupt message request.
	input  wire logic                          msi_ready, // Message accepted.
	output logic                               irq        // Level interrupt.
);
	import gpio_pkg::*;

	typedef struct packed {
		logic [NUM_PINS*MODE_W-1:0] mode;
		logic [NUM_PINS-1:0]        outv;
		logic [NUM_PINS-1:0]        status;
		logic [NUM_PINS-1:0]        mask;
		logic [NUM_PINS-1:0]        pend;
		logic [31:0]                rdata;
		pin_drive_type              drv;
		msi_req_type                msi;
	} port_state_type;

	port_state_type st_r;
	port_state_type st_nxt;

	logic [NUM_PINS-1:0] level;
	logic [NUM_PINS-1:0] fall;
	logic [NUM_PINS-1:0] is_irq;

	// Mode of one pin out of the packed field.
	function automatic pin_mode_type mode_of(input logic [NUM_PINS*MODE_W-1:0] m,
		input int idx);
		return pin_mode_type'(m[idx*MODE_W +: MODE_W]);
	endfunction

	pin_sync #(.WIDTH(NUM_PINS)) u_sync (
		.clk   (clk),
		.reset (reset),
		.din   (pin_in),
		.level (level),
		.fall  (fall)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Pin interrupt qualification per pin.
	genvar g;
	generate
		for (g = 0; g < NUM_PINS; g++) begin : g_pin
			assign is_irq[g] = (mode_of(st_r.mode, g) == MODE_IRQ);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Next state: registers, pin drive, pending messages and read data.
	always_comb begin
		logic [NUM_PINS-1:0] pend_v;
		logic                found;
		pend_v = '0;
		found  = 1'b0;
		st_nxt = st_r;
		st_nxt.rdata = '0;

		// Register writes; the level register ignores writes.
		if (bus.wr) begin
			case (bus.addr)
				OFS_MODE:       st_nxt.mode = bus.wdata[NUM_PINS*MODE_W-1:0];
				OFS_OUT:        st_nxt.outv = bus.wdata[NUM_PINS-1:0];
				OFS_IRQ_MASK:   st_nxt.mask = bus.wdata[NUM_PINS-1:0];
				OFS_IRQ_STATUS: st_nxt.status = st_r.status & ~bus.wdata[NUM_PINS-1:0];
				default:        st_nxt.mode = st_r.mode;
			endcase
		end

		// New edges set status and pending after the clear, so a set wins.
		st_nxt.status = st_nxt.status | (fall & is_irq);
		pend_v = st_r.pend | (fall & is_irq);

		// Issue one message at a time, lowest pin first; vector equals pin number.
		if (st_r.msi.valid && msi_ready) begin
			st_nxt.msi.valid = 1'b0;
		end
		if (!st_nxt.msi.valid) begin
			for (int i = 0; i < NUM_PINS; i++) begin
				if (pend_v[i] && !found) begin
					found            = 1'b1;
					pend_v[i]        = 1'b0;
					st_nxt.msi.valid = 1'b1;
					st_nxt.msi.vector = 2'(i);
				end
			end
		end
		st_nxt.pend = pend_v;

		// Pin drive from the updated mode and value.
		for (int i = 0; i < NUM_PINS; i++) begin
			case (mode_of(st_nxt.mode, i))
				MODE_PUSH: begin
					st_nxt.drv.oe[i]  = 1'b1;
					st_nxt.drv.out[i] = st_nxt.outv[i];
				end
				MODE_DRAIN: begin
					st_nxt.drv.oe[i]  = ~st_nxt.outv[i];
					st_nxt.drv.out[i] = 1'b0;
				end
				default: begin
					st_nxt.drv.oe[i]  = 1'b0;
					st_nxt.drv.out[i] = 1'b0;
				end
			endcase
		end

		// Read data for the next cycle; unmapped reads return zero.
		if (bus.rd) begin
			case (bus.addr)
				OFS_MODE:       st_nxt.rdata = 32'(st_r.mode);
				OFS_LEVEL:      st_nxt.rdata = 32'(level);
				OFS_OUT:        st_nxt.rdata = 32'(st_r.outv);
				OFS_IRQ_STATUS: st_nxt.rdata = 32'(st_r.status);
				OFS_IRQ_MASK:   st_nxt.rdata = 32'(st_r.mask);
				default:        st_nxt.rdata = RESET_WORD;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rdata   = st_r.rdata;
	assign pin_drv = st_r.drv;
	assign msi     = st_r.msi;
	assign irq     = |(st_r.status & st_r.mask);

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	a_drain_never_high: assert property (@(posedge clk) disable iff (reset)
		!(pin_drv.oe[0] && pin_drv.out[0] && mode_of(st_r.mode, 0) == MODE_DRAIN))
		else $error("open drain pin driven high");
	a_push_drives_value: assert property (@(posedge clk) disable iff (reset)
		(mode_of(st_r.mode, 1) == MODE_PUSH) |->
		(pin_drv.oe[1] && pin_drv.out[1] == st_r.outv[1]))
		else $error("push pull pin not following value");
	a_input_not_driven: assert property (@(posedge clk) disable iff (reset)
		(mode_of(st_r.mode, 2) == MODE_INPUT) |-> !pin_drv.oe[2])
		else $error("input pin driven");
	a_level_read_zero: assert property (@(posedge clk) disable iff (reset)
		(bus.rd && bus.addr == OFS_LEVEL) |=>
		(rdata[31:NUM_PINS] == '0 && rdata[NUM_PINS-1:0] == $past(level)))
		else $error("level read wrong");
	a_edge_sets_status: assert property (@(posedge clk) disable iff (reset)
		(fall[3] && is_irq[3]) |=> st_r.status[3])
		else $error("falling edge lost");
	a_no_irq_in_input: assert property (@(posedge clk) disable iff (reset)
		(!is_irq[0] && !st_r.pend[0] && !(msi.valid && msi.vector == 2'h0)) |=>
		!(msi.valid && $rose(msi.valid) && msi.vector == 2'h0))
		else $error("message from non interrupt pin");
	a_msi_holds: assert property (@(posedge clk) disable iff (reset)
		(msi.valid && !msi_ready) |=> (msi.valid && $stable(msi.vector)))
		else $error("message dropped before accept");
	// A status bit only drops through a write of one to it; anything else that
	// cleared it would lose an event before software had seen it.
	a_status_sticky: assert property (@(posedge clk) disable iff (reset)
		!(bus.wr && bus.addr == OFS_IRQ_STATUS) |=>
		((st_r.status & $past(st_r.status)) == $past(st_r.status)))
		else $error("status bit lost without clear");
	// Read data stand for one cycle only, so an idle bus shows zero.
	a_rdata_idle_zero: assert property (@(posedge clk) disable iff (reset)
		!bus.rd |=> (rdata == '0))
		else $error("read data outside read cycle");

	////////////////////////////////////////////////////////////////////////////////
	// Per-pin checks; each pin carries the same guards, so a slip in the index
	// arithmetic of one mode field shows up on that pin alone.
	generate
		for (g = 0; g < NUM_PINS; g++) begin : g_pin_chk
			// A released open-drain pin is left to the pull-up, never driven.
			a_drain_release: assert property (@(posedge clk) disable iff (reset)
				(mode_of(st_r.mode, g) == MODE_DRAIN && st_r.outv[g]) |->
				!pin_drv.oe[g])
				else $error("open drain pin not released");
			// A low value on an open-drain pin pulls it down actively.
			a_drain_pulls_low: assert property (@(posedge clk) disable iff (reset)
				(mode_of(st_r.mode, g) == MODE_DRAIN && !st_r.outv[g]) |->
				(pin_drv.oe[g] && !pin_drv.out[g]))
				else $error("open drain pin not pulled low");
			// Interrupt pins are inputs and must never drive.
			a_irq_pin_input: assert property (@(posedge clk) disable iff (reset)
				(mode_of(st_r.mode, g) == MODE_IRQ) |-> !pin_drv.oe[g])
				else $error("interrupt pin driven");
			// A synchronised falling edge on an interrupt pin sets its status bit at the next edge.
			a_fall_sets_bit: assert property (@(posedge clk) disable iff (reset)
				(fall[g] && is_irq[g]) |=> st_r.status[g])
				else $error("falling edge did not set status");
			// Without a falling edge a clear status bit stays clear.
			a_no_rise_set: assert property (@(posedge clk) disable iff (reset)
				(!fall[g] && !st_r.status[g]) |=> !st_r.status[g])
				else $error("status set without falling edge");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Coverage of the main scenarios.
	c_msi_sent: cover property (@(posedge clk) msi.valid && msi_ready);
	c_drain_low: cover property (@(posedge clk)
		pin_drv.oe[0] && mode_of(st_r.mode, 0) == MODE_DRAIN);
	c_irq_up: cover property (@(posedge clk) $rose(irq));
	// A clear and a new edge in one cycle: the set has to win.
	c_set_beats_clear: cover property (@(posedge clk) fall[3] && is_irq[3] && bus.wr
		&& bus.addr == OFS_IRQ_STATUS && bus.wdata[3]);
	// Two messages with no idle cycle between them.
	c_msi_back_to_back: cover property (@(posedge clk)
		(msi.valid && msi_ready) ##1 msi.valid);
endmodule

// *** board_model.sv ***
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Board side of the pins: a released pin follows the board level.
// The board level idles high, so it also stands in for the open-drain pull-up.
module board_model (
	input  wire gpio_pkg::pin_drive_type          drv, // Drive from the port.
	input  wire logic [gpio_pkg::NUM_PINS-1:0] ext, // Level the board applies.
	output logic      [gpio_pkg::NUM_PINS-1:0] pin  // Resolved wire level.
);
	import gpio_pkg::*;
	// Each wire carries the port's value while enabled, else the board level.
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			pin[i] = drv.oe[i] ? drv.out[i] : ext[i];
		end
	end
endmodule

// *** four_pin_gpio_with_msi_trigger_tb.sv ***
`timescale 1ns/10ps
module four_pin_gpio_with_msi_trigger_tb;
	import gpio_pkg::*;
	logic clk = 0, reset = 1, msi_ready = 0, irq;
	bus_req_type bus = '0;
	logic [31:0] rdata;
	logic [3:0] ext = 4'hf, pin;
	pin_drive_type drv;
	msi_req_type msi;
	int bad_count = 0, n_compared = 0;
	// Rows: mode, output value, board level, expected enable, expected level.
	logic [23:0] rows [4] = '{24'h00f505, 24'h55a5fa, 24'haa6f96, 24'hffff0f};
	always #5 clk = ~clk;
	gpio_port gpio_port_inst (.clk(clk), .reset(reset), .bus(bus), .rdata(rdata),
		.pin_in(pin), .pin_drv(drv), .msi(msi), .msi_ready(msi_ready), .irq(irq));
	board_model board_model_inst (.drv(drv), .ext(ext), .pin(pin));
	////////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One bus cycle; the strobe drops at the next edge so calls never collide.
	task acc(input logic [11:0] a, input logic [31:0] d, input logic w);
		@(posedge clk);
		bus <= '{a, d, w, !w};
		@(posedge clk);
		bus <= '0;
	endtask
	task rd(input logic [11:0] a, input logic [31:0] exp);
		acc(a, 32'h0, 1'b0);
		#1 chk(rdata, exp);
	endtask
	// Bounded wait for a message, then accept it for one cycle.
	// Step off the edge first, so a message launched at this edge is not read stale.
	task take_msi(input logic [1:0] vec);
		#1;
		for (int k = 0; k < 20 && msi.valid !== 1'b1; k++) @(posedge clk) #1;
		chk(32'(msi.valid), 32'h1);
		chk(32'(msi.vector), 32'(vec));
		@(posedge clk) msi_ready <= 1'b1;
		@(posedge clk) msi_ready <= 1'b0;
	endtask
	task wrap_up;
		$display("compared %0d, wrong %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Watchdog: the whole run needs well under a thousand cycles.
	initial begin
		#20000;
		bad_count++;
		wrap_up;
	end
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		#1 chk(32'({drv, msi, irq}), 32'h0);
		chk(rdata, 32'h0);
		rd(OFS_MODE, 32'h0);
		rd(OFS_OUT, 32'h0);
		rd(OFS_IRQ_STATUS, 32'h0);
		rd(12'h400, 32'h0);
		acc(OFS_LEVEL, 32'hffffffff, 1'b1);
		rd(OFS_LEVEL, 32'hf);
		$display("done: reset");
		// Falls on pins 1 and 3 in input mode must stay silent.
		foreach (rows[i]) begin
			acc(OFS_MODE, 32'(rows[i][23:16]), 1'b1);
			acc(OFS_OUT, 32'(rows[i][15:12]), 1'b1);
			@(posedge clk) ext <= rows[i][11:8];
			repeat (4) @(posedge clk);
			#1 chk(32'(drv.oe), 32'(rows[i][7:4]));
			rd(OFS_LEVEL, 32'(rows[i][3:0]));
			rd(OFS_OUT, 32'(rows[i][15:12]));
			rd(OFS_MODE, 32'(rows[i][23:16]));
		end
		rd(OFS_IRQ_STATUS, 32'h0);
		$display("done: table");
		// Two pins fall together; the lower vector goes first.
		acc(OFS_IRQ_MASK, 32'h5, 1'b1);
		@(posedge clk) ext <= 4'ha;
		take_msi(2'h0);
		take_msi(2'h2);
		#1 chk(32'(irq), 32'h1);
		rd(OFS_IRQ_STATUS, 32'h5);
		acc(OFS_IRQ_STATUS, 32'h1, 1'b1);
		acc(OFS_IRQ_MASK, 32'h1, 1'b1);
		rd(OFS_IRQ_STATUS, 32'h4);
		#1 chk(32'(irq), 32'h0);
		// Rising edges raise nothing.
		@(posedge clk) ext <= 4'hf;
		repeat (6) @(posedge clk);
		#1 chk(32'(msi.valid), 32'h0);
		rd(OFS_IRQ_STATUS, 32'h4);
		acc(OFS_IRQ_STATUS, 32'h4, 1'b1);
		rd(OFS_IRQ_STATUS, 32'h0);
		// Pins 1 and 3 fall together and their vectors follow in order.
		@(posedge clk) ext <= 4'h5;
		take_msi(2'h1);
		take_msi(2'h3);
		rd(OFS_IRQ_STATUS, 32'ha);
		acc(OFS_IRQ_MASK, 32'h8, 1'b1);
		#1 chk(32'(irq), 32'h1);
		acc(OFS_IRQ_STATUS, 32'h2, 1'b1);
		// A clear landing in the very cycle of a new edge loses; the bit stays set.
		@(posedge clk) ext <= 4'hf;
		repeat (4) @(posedge clk);
		ext <= 4'h7;
		@(posedge clk);
		acc(OFS_IRQ_STATUS, 32'h8, 1'b1);
		take_msi(2'h3);
		rd(OFS_IRQ_STATUS, 32'h8);
		#1 chk(32'(irq), 32'h1);
		acc(OFS_IRQ_STATUS, 32'h8, 1'b1);
		rd(OFS_IRQ_STATUS, 32'h0);
		#1 chk(32'(irq), 32'h0);
		$display("done: interrupts");
		// Reset in mid-run with all pins driven puts every pin back to input.
		acc(OFS_MODE, 32'h55, 1'b1);
		#1 chk(32'(drv.oe), 32'hf);
		@(posedge clk) reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		#1 chk(32'({drv, msi, irq}), 32'h0);
		chk(rdata, 32'h0);
		rd(OFS_MODE, 32'h0);
		rd(OFS_OUT, 32'h0);
		rd(OFS_LEVEL, 32'h7);
		$display("done: second reset");
		wrap_up;
	end
endmodule
